// ---- common/stack_exec_defs.svh ----
// Offsets, field positions, reset values and opcodes of the stack and carry-clear unit
`ifndef STACK_EXEC_DEFS_SVH
`define STACK_EXEC_DEFS_SVH

// ==========================================
// APB map (byte addresses on a 12-bit paddr)
`define CMD_OFF 12'h000
`define FLAGS_OFF 12'h004
`define MEM_WIN_SEL 2'h1
// Stack pointer index in register space; its APB byte address is four times this
`define SP_REG_IDX 8'hD9
`define FLAGS_REG_IDX 8'hD5

// ==========================================
// Fields
`define CARRY_BIT 7
`define CMD_OPC_LSB 0
`define CMD_OPR_LSB 8
`define SP_RESET 8'h00
`define FLAGS_RESET 8'h00

// ==========================================
// Opcodes
`define OPC_POP_DIR 8'h50
`define OPC_POP_IND 8'h51
`define OPC_PUSH_DIR 8'h70
`define OPC_PUSH_IND 8'h71
`define OPC_CARRY_CLR 8'hCF

`endif

// ---- common/stack_exec_pkg.sv ----
// Types shared by the stack and carry-clear unit
package stack_exec_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_PTR_RD,
    S_PTR_GET,
    S_DAT_RD,
    S_DAT_GET,
    S_DEC,
    S_WRITE,
    S_INC,
    S_MEM_RET
  } state_t;

  typedef enum logic [1:0] {
    RD_MEM,
    RD_SP,
    RD_FLAGS
  } rd_src_t;

endpackage

// ---- hw/reg_space_mem.sv ----
// Single-port 256 x 8 register space with registered read data
`timescale 1ns/1ps

module reg_space_mem (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:255];
  logic [7:0] rdata_q;

  // Array has no reset: software sees undefined contents until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;

endmodule // reg_space_mem

// ---- hw/stack_exec.sv ----
// Push, pop and carry-clear execution unit with an APB register port
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "stack_exec_defs.svh"

// What this block does
// - Stack pointer is 8-bit register 0D9H
// - Pop copies stack byte, then increments pointer
// - Indirect pop writes the pointed-to register
// - Push decrements pointer before the stack write
// - Push stores source at new pointer, source kept
// - Indirect push stacks the pointed-to register
// - Carry clear forces carry to zero
// - Carry clear keeps all other flags
module stack_exec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic [7:0] stack_pointer,
  output logic [7:0] flags
);

  // ==========================================
  // State
  stack_exec_pkg::state_t state_q, state_d;
  stack_exec_pkg::rd_src_t rd_src_q, rd_src_d;
  logic [7:0] stack_pointer_q, stack_pointer_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] opc_q, opc_d;
  logic [7:0] operand_q, operand_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] data_q, data_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic busy_q, busy_d;

  logic [7:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] rd_value;
  logic [7:0] wr_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic access;
  logic is_push;
  logic is_ind;
  logic opc_legal;

  reg_space_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign access = psel && penable && !pready_q;
  assign is_push = (opc_q == `OPC_PUSH_DIR) || (opc_q == `OPC_PUSH_IND);
  assign is_ind = opc_q[0];
  assign opc_legal = (pwdata[7:0] == `OPC_POP_DIR) || (pwdata[7:0] == `OPC_POP_IND) ||
                     (pwdata[7:0] == `OPC_PUSH_DIR) || (pwdata[7:0] == `OPC_PUSH_IND) ||
                     (pwdata[7:0] == `OPC_CARRY_CLR);

  // Stack pointer and flags live in flops but answer at their register-space addresses
  always_comb begin
    case (rd_src_q)
      stack_exec_pkg::RD_SP: rd_value = stack_pointer_q;
      stack_exec_pkg::RD_FLAGS: rd_value = flags_q;
      default: rd_value = mem_rdata;
    endcase
  end

  // ==========================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    stack_pointer_d = stack_pointer_q;
    flags_d = flags_q;
    opc_d = opc_q;
    operand_d = operand_q;
    ptr_d = ptr_q;
    data_d = data_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    mem_addr = operand_q;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    case (state_q)
      stack_exec_pkg::S_IDLE: begin
        if (access) begin
          pready_d = 1'b1;
          prdata_d = 32'h0000_0000;
          if (paddr == `CMD_OFF) begin
            if (!pwrite) begin
              prdata_d = {16'h0000, operand_q, opc_q};
            end else if (!opc_legal) begin
              pslverr_d = 1'b1;
            end else begin
              opc_d = pwdata[`CMD_OPC_LSB +: 8];
              operand_d = pwdata[`CMD_OPR_LSB +: 8];
              if (pwdata[7:0] == `OPC_CARRY_CLR) begin
                flags_d[`CARRY_BIT] = 1'b0;
              end else begin
                pready_d = 1'b0;
                if (pwdata[7:0] == `OPC_PUSH_IND) begin
                  state_d = stack_exec_pkg::S_PTR_RD;
                end else begin
                  state_d = stack_exec_pkg::S_DAT_RD;
                end
              end
            end
          end else if (paddr == `FLAGS_OFF) begin
            prdata_d = {24'h000000, flags_q};
            if (pwrite) begin
              flags_d = pwdata[7:0];
            end
          end else if (paddr == {2'b00, `SP_REG_IDX, 2'b00}) begin
            prdata_d = {24'h000000, stack_pointer_q};
            if (pwrite) begin
              stack_pointer_d = pwdata[7:0];
            end
          end else if (paddr[11:10] == `MEM_WIN_SEL) begin
            mem_addr = paddr[9:2];
            if (pwrite) begin
              wr_en = 1'b1;
              wr_addr = paddr[9:2];
              wr_data = pwdata[7:0];
            end else begin
              pready_d = 1'b0;
              state_d = stack_exec_pkg::S_MEM_RET;
            end
          end else begin
            pslverr_d = 1'b1;
          end
        end
      end
      stack_exec_pkg::S_MEM_RET: begin
        prdata_d = {24'h000000, rd_value};
        pready_d = 1'b1;
        state_d = stack_exec_pkg::S_IDLE;
      end
      stack_exec_pkg::S_PTR_RD: begin
        mem_addr = operand_q;
        state_d = stack_exec_pkg::S_PTR_GET;
      end
      stack_exec_pkg::S_PTR_GET: begin
        ptr_d = rd_value;
        state_d = is_push ? stack_exec_pkg::S_DAT_RD : stack_exec_pkg::S_WRITE;
      end
      stack_exec_pkg::S_DAT_RD: begin
        if (is_push) begin
          mem_addr = is_ind ? ptr_q : operand_q;
        end else begin
          mem_addr = stack_pointer_q;
        end
        state_d = stack_exec_pkg::S_DAT_GET;
      end
      stack_exec_pkg::S_DAT_GET: begin
        data_d = rd_value;
        if (is_push) begin
          state_d = stack_exec_pkg::S_DEC;
        end else if (is_ind) begin
          state_d = stack_exec_pkg::S_PTR_RD;
        end else begin
          state_d = stack_exec_pkg::S_WRITE;
        end
      end
      stack_exec_pkg::S_DEC: begin
        stack_pointer_d = stack_pointer_q - 8'h01;
        state_d = stack_exec_pkg::S_WRITE;
      end
      stack_exec_pkg::S_WRITE: begin
        wr_en = 1'b1;
        wr_data = data_q;
        if (is_push) begin
          wr_addr = stack_pointer_q;
          state_d = stack_exec_pkg::S_IDLE;
          pready_d = 1'b1;
        end else begin
          wr_addr = is_ind ? ptr_q : operand_q;
          state_d = stack_exec_pkg::S_INC;
        end
        mem_addr = wr_addr;
      end
      stack_exec_pkg::S_INC: begin
        stack_pointer_d = stack_pointer_q + 8'h01;
        state_d = stack_exec_pkg::S_IDLE;
        pready_d = 1'b1;
      end
      default: begin
        state_d = stack_exec_pkg::S_IDLE;
      end
    endcase
    // A write landing on the pointer or flag address goes to the flop, not the array
    mem_we = 1'b0;
    mem_wdata = wr_data;
    if (wr_en) begin
      if (wr_addr == `SP_REG_IDX) begin
        stack_pointer_d = wr_data;
      end else if (wr_addr == `FLAGS_REG_IDX) begin
        flags_d = wr_data;
      end else begin
        mem_we = 1'b1;
      end
    end
    if (mem_addr == `SP_REG_IDX) begin
      rd_src_d = stack_exec_pkg::RD_SP;
    end else if (mem_addr == `FLAGS_REG_IDX) begin
      rd_src_d = stack_exec_pkg::RD_FLAGS;
    end else begin
      rd_src_d = stack_exec_pkg::RD_MEM;
    end
    busy_d = (state_d != stack_exec_pkg::S_IDLE);
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= stack_exec_pkg::S_IDLE;
      rd_src_q <= stack_exec_pkg::RD_MEM;
      stack_pointer_q <= `SP_RESET;
      flags_q <= `FLAGS_RESET;
      opc_q <= 8'h00;
      operand_q <= 8'h00;
      ptr_q <= 8'h00;
      data_q <= 8'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rd_src_q <= rd_src_d;
      stack_pointer_q <= stack_pointer_d;
      flags_q <= flags_d;
      opc_q <= opc_d;
      operand_q <= operand_d;
      ptr_q <= ptr_d;
      data_q <= data_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      busy_q <= busy_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;
  assign stack_pointer = stack_pointer_q;
  assign flags = flags_q;

  // ==========================================
  // Assertions
  a_sp_apb_read: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_IDLE && access && !pwrite && paddr == {2'b00, `SP_REG_IDX, 2'b00})
    |=> prdata_q[7:0] == $past(stack_pointer_q) && pready_q)
    else $error("stack pointer read mismatch");
  a_pop_copy_inc: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_DAT_RD && !is_push)
    |-> mem_addr == stack_pointer_q ##1 stack_pointer_q == $past(stack_pointer_q) [*1] ##[1:4]
        (state_q == stack_exec_pkg::S_INC))
    else $error("pop order broken");
  a_pop_inc_after: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_INC)
    |=> state_q == stack_exec_pkg::S_IDLE && stack_pointer_q == $past(stack_pointer_q) + 8'h01)
    else $error("pop did not increment last");
  a_pop_ind_dst: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_WRITE && !is_push && is_ind)
    |-> wr_addr == ptr_q && operand_q == $past(operand_q))
    else $error("indirect pop target wrong");
  a_push_dec_first: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_DEC)
    |=> state_q == stack_exec_pkg::S_WRITE && stack_pointer_q == $past(stack_pointer_q) - 8'h01)
    else $error("push did not decrement first");
  a_push_store: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_WRITE && is_push)
    |-> wr_en && wr_addr == stack_pointer_q && wr_data == data_q)
    else $error("push stored at wrong place");
  a_push_ind_src: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_DAT_RD && is_push && is_ind) |-> mem_addr == ptr_q)
    else $error("indirect push read wrong register");
  a_carry_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_IDLE && access && pwrite && paddr == `CMD_OFF &&
     pwdata[7:0] == `OPC_CARRY_CLR) |=> !flags_q[`CARRY_BIT] && pready_q)
    else $error("carry not cleared");
  a_carry_others: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == stack_exec_pkg::S_IDLE && access && pwrite && paddr == `CMD_OFF &&
     pwdata[7:0] == `OPC_CARRY_CLR) |=> flags_q[6:0] == $past(flags_q[6:0]))
    else $error("carry clear touched other flags");
  a_flags_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q != stack_exec_pkg::S_IDLE && !(wr_en && wr_addr == `FLAGS_REG_IDX))
    |=> flags_q == $past(flags_q))
    else $error("stack op changed flags");

endmodule // stack_exec

// ---- testbench/test_stack_push_pop_carry_clear.sv ----
// Self-checking testbench for the push, pop and carry-clear unit
`timescale 1ns/1ps
`include "stack_exec_defs.svh"

module test_stack_push_pop_carry_clear;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [7:0] stack_pointer;
  logic [7:0] flags;
  logic [7:0] mem [0:255];
  logic [7:0] exp_sp;
  logic [7:0] exp_flags;
  logic [7:0] rnd = 8'h31;
  logic [7:0] v;
  logic [7:0] sel;
  logic [31:0] rd;
  logic er;
  logic bz;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int depth = 0;
  localparam logic [11:0] SP_ADDR = {2'h0, `SP_REG_IDX, 2'h0};

  stack_exec u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(busy),
    .stack_pointer(stack_pointer),
    .flags(flags)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ==========================================
  // Helpers
  function automatic logic [7:0] roll();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction

  function automatic logic [11:0] win(input logic [7:0] n);
    return {`MEM_WIN_SEL, n, 2'h0};
  endfunction

  task automatic finish_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Request held until the rising edge that samples pready high; answer taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    bz = 1'b0;
    do begin
      @(posedge clk);
      bz = bz | busy;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  task automatic setm(input logic [7:0] n, input logic [7:0] val);
    mem[n] = val;
    wr(win(n), {24'h0, val});
  endtask

  task automatic cmd(input logic [7:0] opc, input logic [7:0] opr, input logic bad);
    apb(1'b1, `CMD_OFF, {16'h0, opr, opc});
    chk({31'h0, er}, {31'h0, bad});
    // Only a real stack operation may show busy while the command waits
    chk({31'h0, bz}, {31'h0, (!bad && opc != `OPC_CARRY_CLR)});
  endtask

  task automatic push(input logic ind, input logic [7:0] r);
    v = ind ? mem[mem[r]] : mem[r];
    exp_sp = exp_sp - 8'h01;
    mem[exp_sp] = v;
    depth++;
    cmd(ind ? `OPC_PUSH_IND : `OPC_PUSH_DIR, r, 1'b0);
  endtask

  // Pop into the pointer register sees the write before the increment
  task automatic pop(input logic ind, input logic [7:0] r);
    logic [7:0] dst;
    dst = ind ? mem[r] : r;
    v = mem[exp_sp];
    exp_sp = exp_sp + 8'h01;
    depth--;
    if (dst == `SP_REG_IDX) exp_sp = v + 8'h01;
    else if (dst == `FLAGS_REG_IDX) exp_flags = v;
    else mem[dst] = v;
    cmd(ind ? `OPC_POP_IND : `OPC_POP_DIR, r, 1'b0);
  endtask

  task automatic state;
    @(negedge clk);
    chk(stack_pointer, exp_sp);
    chk(flags, exp_flags);
    chk(busy, 1'b0);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test;
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    exp_sp = `SP_RESET;
    exp_flags = `FLAGS_RESET;
    state();
    rchk(SP_ADDR, `SP_RESET);
    for (int i = 0; i < 64; i++) setm(i[7:0], roll() & 8'h3F);
    setm(8'h40, 8'h4F);
    setm(8'h4F, 8'hAA);
    setm(8'h00, 8'h01);
    wr(SP_ADDR, 32'h000000C0);
    exp_sp = 8'hC0;
    push(1'b0, 8'h40);
    push(1'b1, 8'h40);
    state();
    rchk(win(8'hBF), 8'h4F);
    rchk(win(8'hBE), 8'hAA);
    rchk(win(8'h40), 8'h4F);
    pop(1'b1, 8'h00);
    pop(1'b0, 8'h41);
    state();
    rchk(win(8'h00), 8'h01);
    rchk(win(8'h01), 8'hAA);
    rchk(SP_ADDR, 8'hC0);
    setm(8'h01, 8'h01);
    for (int i = 0; i < 2; i++) begin
      exp_flags = (i == 0) ? (roll() | 8'h80) : (roll() & 8'h7F);
      wr(`FLAGS_OFF, {24'h0, exp_flags});
      cmd(`OPC_CARRY_CLR, 8'h00, 1'b0);
      exp_flags[`CARRY_BIT] = 1'b0;
      state();
      rchk(`FLAGS_OFF, exp_flags);
    end
    setm(8'h60, roll());
    push(1'b0, 8'h60);
    pop(1'b0, `FLAGS_REG_IDX);
    state();
    setm(8'h50, 8'hA0);
    push(1'b0, 8'h50);
    pop(1'b0, `SP_REG_IDX);
    state();
    wr(SP_ADDR, 32'h000000C0);
    exp_sp = 8'hC0;
    cmd(8'h00, 8'h00, 1'b1);
    // A refused command leaves the last accepted one in place
    apb(1'b0, `CMD_OFF, 32'h0);
    chk(rd, {16'h0, `SP_REG_IDX, `OPC_POP_DIR});
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    state();
    for (int i = 0; i < 40; i++) begin
      sel = roll();
      if (depth == 0 || sel[0]) push(sel[1], roll() & 8'h3F);
      else pop(sel[1], roll() & 8'h3F);
      state();
    end
    for (int i = 0; i < 64; i++) rchk(win(i[7:0]), mem[i]);
    finish_test;
  end
endmodule // test_stack_push_pop_carry_clear
